// file: i2c_master_event_pkg.sv
// Package with register map, field positions and timing constants for the event sequencer
// Summary of operation
// RULE_01 - Transmit buffer write during shifting sets write collision, buffer unchanged
// RULE_02 - Write collision flag stays set until software clears it
// RULE_03 - Event-enable bit writes ignored while any master event runs
// RULE_04 - Transmit write sets buffer full, starts timer, drives MSB, clock low, status set
// RULE_05 - Each timeout toggles clock; next bit driven after clock seen low
// RULE_06 - Slave may stretch clock; high phase timed only after line seen high (the stop high phase is timed from clock release, without this check)
// RULE_07 - Eighth falling edge releases data and clears buffer full flag
// RULE_08 - Ninth falling edge pulses interrupt, clears transmit status, holds clock low
// RULE_09 - Receive enable bit 3 makes eight clocks, sampling data before each fall
// RULE_10 - Software sets event bits only when all five read zero
// RULE_11 - After eighth receive fall: clear enable, load buffer, set full, interrupt
// RULE_12 - Receive full set on buffer load, cleared by software buffer read
// RULE_13 - Byte completing while full sets overflow, new byte discarded
// RULE_14 - Overflow does not block reception; next byte loads after full clears
// RULE_15 - Transmit write during receive, acknowledge, stop or restart sets collision
// RULE_16 - Acknowledge enable bit 4 drives level chosen by acknowledge data bit 5
// RULE_17 - Acknowledge lasts two baud periods, then clears enable and interrupts
// RULE_18 - Stop enable bit 2: data low, then release clock, release data, finish
// RULE_19 - Stop detected sets stop flag bit 4, clears start flag bit 3
// RULE_20 - Restart bit 1: clock low, release data one count, then release clock
// RULE_21 - Restart reloads timer on clock high, both high one count, data low one count
// RULE_22 - Restart completion sets start flag, clears stop flag, enable, interrupts
// RULE_23 - Ninth transmit clock samples slave acknowledge into status bit 15
// RULE_24 - Interrupt is a one-cycle pulse per completed event
package i2c_master_event_pkg;
  // Register offsets on the plain register port
  localparam logic [1:0] ADDR_CONTROL  = 2'h0;
  localparam logic [1:0] ADDR_STATUS   = 2'h1;
  localparam logic [1:0] ADDR_TRANSMIT = 2'h2;
  localparam logic [1:0] ADDR_RECEIVE  = 2'h3;
  // Control register fields
  localparam int CON_RESTART = 1;
  localparam int CON_STOP    = 2;
  localparam int CON_RECEIVE = 3;
  localparam int CON_ACK     = 4;
  localparam int CON_ACKDATA = 5;
  localparam logic [4:0] EVENT_BITS_MASK = 5'h1E;
  // Status register fields
  localparam int STAT_TXFULL   = 0;
  localparam int STAT_RXFULL   = 1;
  localparam int STAT_START    = 3;
  localparam int STAT_STOP     = 4;
  localparam int STAT_OVERFLOW = 6;
  localparam int STAT_WCOL     = 7;
  localparam int STAT_TRANSMIT_STATUS_FLAG   = 14;
  localparam int STAT_ACKNOWLEDGE_STATUS_FLAG  = 15;
  // Reset values, bit indices and the one-count timer step
  localparam logic [15:0] STATUS_RESET  = 16'h0000;
  localparam logic [15:0] BAUD_RESET    = 16'h0004;
  localparam logic [3:0]  LAST_BIT      = 4'h7;
  localparam logic [3:0]  ACK_BIT       = 4'h8;
  localparam logic [15:0] COUNT_ONE     = 16'h0001;
  typedef enum logic [3:0] {
    IDLE       = 4'h0,
    TX_LOW     = 4'h1,
    TX_HIGH    = 4'h2,
    RX_LOW     = 4'h3,
    RX_HIGH    = 4'h4,
    ACK_LOW    = 4'h5,
    ACK_HIGH   = 4'h6,
    STOP_A     = 4'h7,
    STOP_B     = 4'h8,
    STOP_C     = 4'h9,
    RS_CLK_LOW = 4'hA,
    RS_SDA_REL = 4'hB,
    RS_BOTH_HI = 4'hC,
    RS_SDA_LOW = 4'hD
  } phase_e;
endpackage

// file: i2c_master_event_sequencer.sv
// Master event sequencer: register port, baud timer, bus event state machine
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module i2c_master_event_sequencer
  import i2c_master_event_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [1:0]  address,
  input  wire logic [15:0] write_data,
  input  wire logic        write_strobe,
  input  wire logic        read_strobe,
  output logic      [15:0] read_data,
  input  wire logic [15:0] baud_count_period,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             master_event_interrupt
);

  typedef struct packed {
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    phase_e      phase;
    logic [15:0] baud_count;
    logic        timer_run;
    logic [3:0]  bit_count;
    logic        clock_seen_low;
    logic [5:0]  control_register;
    logic [15:0] status_register;
    logic [7:0]  transmit_buffer;
    logic [7:0]  receive_shift_register;
    logic [7:0]  receive_buffer;
    logic [15:0] read_data;
    logic        scl_low;
    logic        sda_low;
    logic        interrupt;
  } state_s;

  state_s cur;
  state_s next_cur;

  // Baud timer reload helper
  function automatic logic [15:0] reload(input logic [15:0] period);
    reload = (period == 16'h0000) ? COUNT_ONE : period;
  endfunction

  logic scl_hi;
  logic sda_hi;
  logic timeout;
  logic busy;
  assign scl_hi  = cur.scl_sync[1];
  assign sda_hi  = cur.sda_sync[1];
  assign timeout = cur.timer_run && (cur.baud_count == COUNT_ONE);
  assign busy    = (cur.phase != IDLE);

  // Next-state logic for the whole block
  always_comb begin
    next_cur = cur;
    next_cur.scl_sync = {cur.scl_sync[0], scl_in};
    next_cur.sda_sync = {cur.sda_sync[0], sda_in};
    next_cur.interrupt = 1'b0; // RULE_24
    next_cur.read_data = 16'h0000;
    if (cur.timer_run && !timeout) begin
      next_cur.baud_count = cur.baud_count - COUNT_ONE;
    end
    // Register reads; a receive buffer read clears the full flag
    if (read_strobe) begin
      unique case (address)
        ADDR_CONTROL:  next_cur.read_data = {10'h000, cur.control_register};
        ADDR_STATUS:   next_cur.read_data = cur.status_register;
        ADDR_TRANSMIT: next_cur.read_data = {8'h00, cur.transmit_buffer};
        ADDR_RECEIVE: begin
          next_cur.read_data = {8'h00, cur.receive_buffer};
          next_cur.status_register[STAT_RXFULL] = 1'b0; // RULE_12
        end
      endcase
    end
    // Register writes
    if (write_strobe) begin
      unique case (address)
        ADDR_CONTROL: begin
          next_cur.control_register[CON_ACKDATA] = write_data[CON_ACKDATA];
          if (!busy) begin // RULE_03
            next_cur.control_register[4:0] = write_data[4:0] & EVENT_BITS_MASK;
          end
        end
        ADDR_STATUS: begin
          // Software clears only the sticky error flags by writing zero
          if (!write_data[STAT_WCOL]) begin
            next_cur.status_register[STAT_WCOL] = 1'b0; // RULE_02
          end
          if (!write_data[STAT_OVERFLOW]) begin
            next_cur.status_register[STAT_OVERFLOW] = 1'b0;
          end
        end
        ADDR_TRANSMIT: begin
          if (busy) begin
            next_cur.status_register[STAT_WCOL] = 1'b1; // RULE_01 RULE_15
          end else begin
            next_cur.transmit_buffer = write_data[7:0];
            next_cur.status_register[STAT_TXFULL] = 1'b1; // RULE_04
            next_cur.status_register[STAT_TRANSMIT_STATUS_FLAG] = 1'b1;
            next_cur.phase = TX_LOW;
            next_cur.bit_count = 4'h0;
            next_cur.scl_low = 1'b1;
            next_cur.sda_low = ~write_data[7];
            next_cur.clock_seen_low = 1'b1;
            next_cur.timer_run = 1'b1;
            next_cur.baud_count = reload(baud_count_period);
          end
        end
        default: begin
        end
      endcase
    end
    // Event launch from the control bits, only when idle
    if (!busy && !(write_strobe && address == ADDR_TRANSMIT)) begin
      if (cur.control_register[CON_RECEIVE]) begin // RULE_09
        next_cur.phase = RX_LOW;
        next_cur.bit_count = 4'h0;
        next_cur.scl_low = 1'b1;
        next_cur.sda_low = 1'b0;
        next_cur.timer_run = 1'b1;
        next_cur.baud_count = reload(baud_count_period);
      end else if (cur.control_register[CON_ACK]) begin // RULE_16
        next_cur.phase = ACK_LOW;
        next_cur.scl_low = 1'b1;
        next_cur.sda_low = ~cur.control_register[CON_ACKDATA];
        next_cur.timer_run = 1'b1;
        next_cur.baud_count = reload(baud_count_period);
      end else if (cur.control_register[CON_STOP]) begin // RULE_18
        next_cur.phase = STOP_A;
        next_cur.scl_low = 1'b1;
        next_cur.sda_low = 1'b1;
        next_cur.timer_run = 1'b1;
        next_cur.baud_count = reload(baud_count_period);
      end else if (cur.control_register[CON_RESTART]) begin // RULE_20
        next_cur.phase = RS_CLK_LOW;
        next_cur.scl_low = 1'b1;
        next_cur.timer_run = 1'b0;
      end
    end
    // Bus event state machine
    unique case (cur.phase)
      IDLE: begin
      end
      TX_LOW: begin
        // Next bit placed only once the clock is seen low
        if (!scl_hi && !cur.clock_seen_low) begin // RULE_05
          next_cur.clock_seen_low = 1'b1;
          if (cur.bit_count == ACK_BIT) begin
            next_cur.sda_low = 1'b0; // RULE_07
            next_cur.status_register[STAT_TXFULL] = 1'b0;
          end else begin
            next_cur.sda_low = ~cur.transmit_buffer[LAST_BIT[2:0] - cur.bit_count[2:0]];
          end
        end
        if (timeout) begin
          next_cur.scl_low = 1'b0; // RULE_05
          next_cur.timer_run = 1'b0;
          next_cur.phase = TX_HIGH;
        end
      end
      TX_HIGH: begin
        // Stretch: timer waits for the line to read high
        if (!cur.timer_run && scl_hi) begin // RULE_06
          next_cur.timer_run = 1'b1;
          next_cur.baud_count = reload(baud_count_period);
        end
        if (timeout) begin
          next_cur.scl_low = 1'b1;
          next_cur.clock_seen_low = 1'b0;
          if (cur.bit_count == ACK_BIT) begin
            next_cur.status_register[STAT_ACKNOWLEDGE_STATUS_FLAG] = sda_hi; // RULE_23
            next_cur.status_register[STAT_TRANSMIT_STATUS_FLAG] = 1'b0; // RULE_08
            next_cur.interrupt = 1'b1;
            next_cur.timer_run = 1'b0;
            next_cur.phase = IDLE;
          end else begin
            next_cur.bit_count = cur.bit_count + 4'h1;
            next_cur.baud_count = reload(baud_count_period);
            next_cur.phase = TX_LOW;
          end
        end
      end
      RX_LOW: begin
        if (timeout) begin
          next_cur.scl_low = 1'b0;
          next_cur.timer_run = 1'b0;
          next_cur.phase = RX_HIGH;
        end
      end
      RX_HIGH: begin
        if (!cur.timer_run && scl_hi) begin // RULE_06
          next_cur.timer_run = 1'b1;
          next_cur.baud_count = reload(baud_count_period);
        end
        if (timeout) begin
          // Sample just before driving the falling edge
          next_cur.receive_shift_register = {cur.receive_shift_register[6:0], sda_hi}; // RULE_09
          next_cur.scl_low = 1'b1;
          if (cur.bit_count == LAST_BIT) begin
            next_cur.control_register[CON_RECEIVE] = 1'b0; // RULE_11
            next_cur.interrupt = 1'b1;
            next_cur.timer_run = 1'b0;
            next_cur.phase = IDLE;
            if (cur.status_register[STAT_RXFULL] && !(read_strobe && address == ADDR_RECEIVE)) begin
              next_cur.status_register[STAT_OVERFLOW] = 1'b1; // RULE_13
            end else begin
              next_cur.receive_buffer = {cur.receive_shift_register[6:0], sda_hi}; // RULE_14
              next_cur.status_register[STAT_RXFULL] = 1'b1; // RULE_12
            end
          end else begin
            next_cur.bit_count = cur.bit_count + 4'h1;
            next_cur.baud_count = reload(baud_count_period);
            next_cur.phase = RX_LOW;
          end
        end
      end
      ACK_LOW: begin
        if (timeout) begin
          next_cur.scl_low = 1'b0;
          next_cur.timer_run = 1'b0;
          next_cur.phase = ACK_HIGH;
        end
      end
      ACK_HIGH: begin
        if (!cur.timer_run && scl_hi) begin // RULE_06
          next_cur.timer_run = 1'b1;
          next_cur.baud_count = reload(baud_count_period);
        end
        if (timeout) begin
          next_cur.scl_low = 1'b1;
          next_cur.sda_low = 1'b0;
          next_cur.control_register[CON_ACK] = 1'b0; // RULE_17
          next_cur.interrupt = 1'b1;
          next_cur.timer_run = 1'b0;
          next_cur.phase = IDLE;
        end
      end
      STOP_A: begin
        if (timeout) begin
          next_cur.scl_low = 1'b0; // RULE_18
          next_cur.baud_count = reload(baud_count_period);
          next_cur.phase = STOP_B;
        end
      end
      STOP_B: begin
        if (timeout) begin
          next_cur.sda_low = 1'b0; // RULE_18
          next_cur.baud_count = reload(baud_count_period);
          next_cur.phase = STOP_C;
        end
      end
      STOP_C: begin
        if (timeout) begin
          next_cur.status_register[STAT_STOP] = 1'b1; // RULE_19
          next_cur.status_register[STAT_START] = 1'b0;
          next_cur.control_register[CON_STOP] = 1'b0;
          next_cur.interrupt = 1'b1;
          next_cur.timer_run = 1'b0;
          next_cur.phase = IDLE;
        end
      end
      RS_CLK_LOW: begin
        if (!scl_hi) begin // RULE_20
          next_cur.sda_low = 1'b0;
          next_cur.timer_run = 1'b1;
          next_cur.baud_count = reload(baud_count_period);
          next_cur.phase = RS_SDA_REL;
        end
      end
      RS_SDA_REL: begin
        if (timeout && sda_hi) begin // RULE_20
          next_cur.scl_low = 1'b0;
          next_cur.timer_run = 1'b0;
          next_cur.phase = RS_BOTH_HI;
        end
      end
      RS_BOTH_HI: begin
        if (!cur.timer_run && scl_hi) begin // RULE_21
          next_cur.timer_run = 1'b1;
          next_cur.baud_count = reload(baud_count_period);
        end
        if (timeout) begin
          next_cur.sda_low = 1'b1; // RULE_21
          next_cur.baud_count = reload(baud_count_period);
          next_cur.phase = RS_SDA_LOW;
        end
      end
      RS_SDA_LOW: begin
        if (timeout) begin
          next_cur.status_register[STAT_START] = 1'b1; // RULE_22
          next_cur.status_register[STAT_STOP] = 1'b0;
          next_cur.control_register[CON_RESTART] = 1'b0;
          next_cur.interrupt = 1'b1;
          next_cur.timer_run = 1'b0;
          next_cur.phase = IDLE;
        end
      end
      default: begin
        next_cur.phase = IDLE;
      end
    endcase
  end

  // State register; lines idle released after reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '{scl_sync: 2'h3, sda_sync: 2'h3, phase: IDLE, baud_count: BAUD_RESET,
               timer_run: 1'b0, bit_count: 4'h0, clock_seen_low: 1'b0,
               control_register: 6'h00, status_register: STATUS_RESET,
               transmit_buffer: 8'h00, receive_shift_register: 8'h00,
               receive_buffer: 8'h00, read_data: 16'h0000, scl_low: 1'b0,
               sda_low: 1'b0, interrupt: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // Open-drain outputs: drive low only, enable marks driving
  assign read_data              = cur.read_data;
  assign scl_out                = 1'b0;
  assign scl_oe                 = cur.scl_low;
  assign sda_out                = 1'b0;
  assign sda_oe                 = cur.sda_low;
  assign master_event_interrupt = cur.interrupt;

endmodule

// file: i2c_master_event_sequencer_assertions.sv
// Port checker for the master event sequencer
`timescale 1ns/1ps
module i2c_master_event_sequencer_checker
  import i2c_master_event_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic [1:0]  address,
  input wire logic [15:0] write_data,
  input wire logic        write_strobe,
  input wire logic        read_strobe,
  input wire logic [15:0] read_data,
  input wire logic [15:0] baud_count_period,
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic        master_event_interrupt
);
  logic        busy;
  logic        wcol_seen;
  logic        ack_lvl;
  logic [2:0]  ev;
  logic [15:0] cnt;
  wire logic   irq   = master_event_interrupt;
  wire logic   wr_tx = write_strobe && address == ADDR_TRANSMIT;
  wire logic   wr_ev = write_strobe && address == ADDR_CONTROL && write_data[4:1] != 4'h0;
  // Shadow of the running event; writes while busy start nothing
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy      <= 1'b0;
      wcol_seen <= 1'b0;
      ack_lvl   <= 1'b0;
      ev        <= 3'h0;
      cnt       <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
      if (!busy && (wr_tx || wr_ev)) begin
        busy    <= 1'b1;
        cnt     <= 16'h0000;
        ack_lvl <= write_data[CON_ACKDATA];
        ev      <= wr_tx ? 3'h0 : write_data[CON_RECEIVE] ? 3'h1 : write_data[CON_ACK] ? 3'h2 :
                   write_data[CON_STOP] ? 3'h3 : 3'h4;
      end else if (irq) begin
        busy <= 1'b0;
      end
      // Sticky: only a status write with the bit low drops it
      if (busy && wr_tx) begin
        wcol_seen <= 1'b1;
      end else if (write_strobe && address == ADDR_STATUS && !write_data[STAT_WCOL]) begin
        wcol_seen <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  sequence s_idle_tx;
    wr_tx && !busy;
  endsequence
  sequence s_msb_out;
    scl_oe && sda_oe == !$past(write_data[7]);
  endsequence
  sequence s_idle_ack;
    wr_ev && !busy && write_data[CON_ACK] && !write_data[CON_RECEIVE];
  endsequence
  property p_tx_start; s_idle_tx |=> s_msb_out; endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx start lines wrong");
  property p_irq_pulse; irq |=> !irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt too long");
  property p_wcol; read_strobe && address == ADDR_STATUS && wcol_seen |=> read_data[STAT_WCOL]; endproperty
  a_wcol: assert property (p_wcol) else $error("collision flag lost");
  property p_ack_lvl; s_idle_ack |=> ##[0:4] sda_oe == !ack_lvl; endproperty
  a_ack_lvl: assert property (p_ack_lvl) else $error("ack level wrong");
  property p_ack_len; irq && ev == 3'h2 |-> cnt >= 2 * baud_count_period && cnt <= 2 * baud_count_period + 12;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack length wrong");
  property p_stop_go; wr_ev && !busy && write_data[4:2] == 3'b001 |=> ##[0:3] sda_oe; endproperty
  a_stop_go: assert property (p_stop_go) else $error("stop data not low");
  property p_stop_end; irq && ev == 3'h3 |-> !scl_oe && !sda_oe; endproperty
  a_stop_end: assert property (p_stop_end) else $error("stop lines not released");
  property p_tx_end; irq && ev == 3'h0 |-> scl_oe && !sda_oe; endproperty
  a_tx_end: assert property (p_tx_end) else $error("tx end lines wrong");
  property p_idle_hold; !busy && !$past(busy) && !$past(busy, 2) |-> $stable(scl_oe); endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("clock moved while idle");
  property p_rs_end; irq && ev == 3'h4 |-> !scl_oe && sda_oe; endproperty
  a_rs_end: assert property (p_rs_end) else $error("restart end lines wrong");
endmodule

// file: i2c_slave_model.sv
// Behavioural slave: acknowledges, sends a byte, stretches the clock
`timescale 1ns/1ps
module i2c_slave_model (
  input  wire logic       clock,
  input  wire logic       arm,
  input  wire logic       send,
  input  wire logic [7:0] tx_byte,
  input  wire logic       stretch,
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            scl_oe,
  output logic            sda_oe,
  output logic [7:0]      got_byte
);
  logic       scl_q = 1'b1;
  logic       seen = 1'b0;
  logic [3:0] slot = 4'hF;
  logic [3:0] hold = 4'h0;
  // Slots advance on falls after a rise, so the opening fall is no bit
  always @(posedge clock) begin
    scl_q <= scl;
    if (arm) begin
      slot <= 4'h0;
      seen <= 1'b0;
    end else if (scl && !scl_q) begin
      seen <= 1'b1;
    end else if (scl_q && !scl && seen && slot != 4'hF) begin
      slot <= slot + 4'h1;
    end
    if (scl && !scl_q && slot < 4'h8) got_byte <= {got_byte[6:0], sda};
    if (scl_q && !scl && stretch) hold <= 4'h6;
    else if (hold != 4'h0) hold <= hold - 4'h1;
  end
  // Stretch keeps the clock low a few cycles past each fall
  assign scl_oe = hold != 4'h0;
  // Data bits MSB first when sending, otherwise acknowledge in slot eight
  assign sda_oe = send ? (slot < 4'h8 && !tx_byte[4'h7 - slot]) : (slot == 4'h8);
endmodule

// file: i2c_master_event_sequencer_test.sv
// Self-checking bench for the master event sequencer
`timescale 1ns/1ps
module i2c_master_event_sequencer_test
  import i2c_master_event_pkg::*;
;
  logic        clock;
  logic        rst_b;
  logic [1:0]  address;
  logic [15:0] write_data;
  logic        write_strobe;
  logic        read_strobe;
  logic [15:0] read_data;
  logic [15:0] baud;
  logic        m_scl_oe;
  logic        m_sda_oe;
  logic        s_scl_oe;
  logic        s_sda_oe;
  logic        irq;
  logic        arm;
  logic        send;
  logic        stretch;
  logic [7:0]  tx_byte;
  logic [7:0]  got_byte;
  int          n_errors = 0;
  int          checks = 0;
  // Pull-ups: a line is low while anyone pulls it
  wire logic   scl = !(m_scl_oe || s_scl_oe);
  wire logic   sda = !(m_sda_oe || s_sda_oe);
  i2c_master_event_sequencer dut_u (
    .clock(clock), .rst_b(rst_b), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .baud_count_period(baud), .scl_in(scl), .scl_out(), .scl_oe(m_scl_oe), .sda_in(sda),
    .sda_out(), .sda_oe(m_sda_oe), .master_event_interrupt(irq));
  i2c_slave_model slave_u (
    .clock(clock), .arm(arm), .send(send), .tx_byte(tx_byte), .stretch(stretch),
    .scl(scl), .sda(sda), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .got_byte(got_byte));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [15:0] exp);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    @(negedge clock);
    chk(read_data, exp);
  endtask
  task automatic wait_irq();
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge clock);
      if (irq === 1'b1) break;
    end
    if (i == 2000) chk(16'h0000, 16'h0001);
  endtask
  task automatic arm_slave(input logic s, input logic [7:0] b, input logic st);
    @(posedge clock);
    arm <= 1'b1;
    send <= s;
    tx_byte <= b;
    stretch <= st;
    @(posedge clock);
    arm <= 1'b0;
  endtask
  // Unanswered byte first: slave never pulls data, so the flag reads high
  task automatic t_tx();
    arm_slave(1'b1, 8'hFF, 1'b0);
    wr(ADDR_TRANSMIT, 16'h00C3);
    wait_irq();
    rd(ADDR_STATUS, 16'h8000);
    chk({8'h00, got_byte}, 16'h00C3);
    arm_slave(1'b0, 8'h00, 1'b1);
    wr(ADDR_TRANSMIT, 16'h00A5);
    rd(ADDR_STATUS, 16'hC001);
    wr(ADDR_TRANSMIT, 16'h005A);
    wait_irq();
    rd(ADDR_STATUS, 16'h0080);
    chk({8'h00, got_byte}, 16'h00A5);
    wr(ADDR_STATUS, 16'h0000);
    rd(ADDR_STATUS, 16'h0000);
  endtask
  task automatic t_rx();
    arm_slave(1'b1, 8'h3C, 1'b0);
    wr(ADDR_CONTROL, 16'h0008);
    wait_irq();
    rd(ADDR_CONTROL, 16'h0000);
    rd(ADDR_STATUS, 16'h0002);
    arm_slave(1'b1, 8'h5A, 1'b1);
    wr(ADDR_CONTROL, 16'h0008);
    wait_irq();
    rd(ADDR_STATUS, 16'h0042);
    rd(ADDR_RECEIVE, 16'h003C);
    rd(ADDR_STATUS, 16'h0040);
    arm_slave(1'b1, 8'h69, 1'b0);
    wr(ADDR_CONTROL, 16'h0008);
    wait_irq();
    rd(ADDR_RECEIVE, 16'h0069);
    wr(ADDR_STATUS, 16'h0000);
  endtask
  // Not-acknowledge first, so the last sampled level is a low one
  task automatic t_ack();
    logic [15:0] lvl;
    for (int i = 0; i < 2; i++) begin
      lvl = (i == 0) ? 16'h0020 : 16'h0000;
      wr(ADDR_CONTROL, lvl | 16'h0010);
      wr(ADDR_CONTROL, lvl | 16'h0008);
      wr(ADDR_TRANSMIT, 16'h00FF);
      wait_irq();
      rd(ADDR_CONTROL, lvl);
      rd(ADDR_STATUS, 16'h0080);
      wr(ADDR_STATUS, 16'h0000);
    end
  endtask
  task automatic t_end(input logic [15:0] cmd, input logic [15:0] exp);
    wr(ADDR_CONTROL, cmd);
    wait_irq();
    rd(ADDR_STATUS, exp);
    rd(ADDR_CONTROL, 16'h0000);
  endtask
  task automatic wrap_up();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    rst_b = 1'b0;
    address = 2'h0;
    write_data = 16'h0000;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    baud = 16'h0004;
    arm = 1'b0;
    send = 1'b0;
    stretch = 1'b0;
    tx_byte = 8'h00;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    rd(ADDR_STATUS, STATUS_RESET);
    t_tx();
    t_rx();
    t_ack();
    t_end(16'h0004, 16'h0010);
    t_end(16'h0002, 16'h0008);
    wrap_up();
  end
  // Watchdog well beyond the several hundred cycles the run needs
  initial begin
    #2000000;
    n_errors++;
    wrap_up();
  end
endmodule
bind i2c_master_event_sequencer i2c_master_event_sequencer_checker chk_u (
  .clock(clock), .rst_b(rst_b), .address(address), .write_data(write_data),
  .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
  .baud_count_period(baud_count_period), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .master_event_interrupt(master_event_interrupt));
